// >>> src/incskip_pkg.sv
// Shared constants, opcodes and types for the increment-skip and read block.
package incskip_pkg;

    // Opcode patterns and masks.
    localparam logic [15:0] OP_MASK_REG = 16'hfe00;
    localparam logic [15:0] OP_MASK_ALL = 16'hffff;
    localparam logic [15:0] OP_INCSNZ_FR = 16'h5a00;
    localparam logic [15:0] OP_INCSNZ_W = 16'h5800;
    localparam logic [15:0] OP_INCSZ_FR = 16'h3e00;
    localparam logic [15:0] OP_INCSZ_W = 16'h3c00;
    localparam logic [15:0] OP_SWINT = 16'h0006;
    localparam logic [15:0] OP_PMREAD = 16'h0019;
    localparam logic [15:0] OP_PMREADI = 16'h001d;

    // Operand field of the register-operand instructions.
    localparam int FR_MSB = 8;
    localparam int FR_WIDTH = 9;

    // Cycle counts of the multi-cycle instructions.
    localparam int SWINT_CYCLES = 3;
    localparam int READ_BLOCK_CYCLES = 4;
    localparam logic [1:0] SWINT_EXTRA = 2'(SWINT_CYCLES - 2);
    localparam logic [1:0] READ_EXTRA = 2'(READ_BLOCK_CYCLES - 2);
    localparam logic [7:0] ADDRL_STEP = 8'h02;

    // Program memory map, as 24-bit byte addresses.
    localparam logic [23:0] PRAM_BASE = 24'h000000;
    localparam logic [23:0] PRAM_LAST = 24'h00ffff;
    localparam logic [23:0] FLASH_BASE = 24'h010000;
    localparam logic [23:0] FLASH_LAST = 24'h01ffff;
    localparam logic [23:0] EXT_BASE = 24'h800000;
    localparam logic [23:0] EXT_LAST = 24'hffffff;

    // APB register byte offsets and reset values.
    localparam logic [11:0] REG_ADDR = 12'h000;
    localparam logic [11:0] REG_DATA = 12'h004;
    localparam logic [11:0] REG_WORK = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00c;
    localparam logic [23:0] ADDR_RESET = 24'h000000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam int ST_READ_BUSY = 0;
    localparam int ST_SKIP = 1;
    localparam int ST_STALL = 2;

    typedef enum logic [2:0] {
        OPC_NONE = 3'b000,
        OPC_INCSNZ_FR = 3'b001,
        OPC_INCSNZ_W = 3'b010,
        OPC_INCSZ_FR = 3'b011,
        OPC_INCSZ_W = 3'b100,
        OPC_SWINT = 3'b101,
        OPC_PMREAD = 3'b110,
        OPC_PMREADI = 3'b111
    } opc_type;

    typedef enum logic [1:0] {
        RGN_NONE = 2'b00,
        RGN_PRAM = 2'b01,
        RGN_FLASH = 2'b10,
        RGN_EXT = 2'b11
    } region_type;

    typedef struct packed {
        logic valid;
        logic [23:0] addr;
    } mem_req_type;

    typedef struct packed {
        logic ack;
        logic [15:0] data;
    } mem_rsp_type;

endpackage

// >>> src/pm_read_engine.sv
// One outstanding program-memory word read with a request/acknowledge port.
`timescale 1ns/1ps
module pm_read_engine
    import incskip_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [23:0] start_addr,
    output logic busy,
    output logic done,
    output logic [15:0] rdata,
    output mem_req_type mem_req,
    input wire mem_rsp_type mem_rsp
);

    logic busy_q;
    logic done_q;
    logic [23:0] addr_q;
    logic [15:0] rdata_q;

    // The request is held steady until the memory side acknowledges it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            addr_q <= 24'h000000;
        end else if (start && !busy_q) begin
            busy_q <= 1'b1;
            addr_q <= start_addr;
        end else if (busy_q && mem_rsp.ack) begin
            busy_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            done_q <= busy_q && mem_rsp.ack;
            if (busy_q && mem_rsp.ack) begin
                rdata_q <= mem_rsp.data;
            end
        end
    end

    assign busy = busy_q || done_q;
    assign done = done_q;
    assign rdata = rdata_q;
    assign mem_req = '{valid: busy_q, addr: addr_q};

endmodule

// >>> src/incskip_exec.sv
// Execution of increment-skip, software interrupt and program reads.
`timescale 1ns/1ps
module incskip_exec
    import incskip_pkg::*;
#(
    parameter int APB_AW = 12
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    output logic instr_ready,
    input wire logic exec_from_pram,
    input wire logic global_irq_enable,
    input wire logic irq_in_service,
    output logic sw_irq,
    output logic skip_pending,
    output logic [FR_WIDTH-1:0] rf_raddr,
    input wire logic [7:0] rf_rdata,
    output logic rf_we,
    output logic [FR_WIDTH-1:0] rf_waddr,
    output logic [7:0] rf_wdata,
    output mem_req_type mem_req,
    input wire mem_rsp_type mem_rsp
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_BLOCK = 2'b10
    } state_type;

    function automatic opc_type decode(input logic [15:0] word);
        opc_type op;
        op = OPC_NONE;
        if ((word & OP_MASK_REG) == OP_INCSNZ_FR) begin
            op = OPC_INCSNZ_FR;
        end else if ((word & OP_MASK_REG) == OP_INCSNZ_W) begin
            op = OPC_INCSNZ_W;
        end else if ((word & OP_MASK_REG) == OP_INCSZ_FR) begin
            op = OPC_INCSZ_FR;
        end else if ((word & OP_MASK_REG) == OP_INCSZ_W) begin
            op = OPC_INCSZ_W;
        end else if ((word & OP_MASK_ALL) == OP_SWINT) begin
            op = OPC_SWINT;
        end else if ((word & OP_MASK_ALL) == OP_PMREAD) begin
            op = OPC_PMREAD;
        end else if ((word & OP_MASK_ALL) == OP_PMREADI) begin
            op = OPC_PMREADI;
        end
        return op;
    endfunction

    function automatic region_type region_of(input logic [23:0] a);
        region_type r;
        r = RGN_NONE;
        if (a >= PRAM_BASE && a <= PRAM_LAST) begin
            r = RGN_PRAM;
        end else if (a >= FLASH_BASE && a <= FLASH_LAST) begin
            r = RGN_FLASH;
        end else if (a >= EXT_BASE && a <= EXT_LAST) begin
            r = RGN_EXT;
        end
        return r;
    endfunction

    function automatic logic is_read(input opc_type op);
        return (op == OPC_PMREAD) || (op == OPC_PMREADI);
    endfunction

    function automatic logic is_fr_form(input opc_type op);
        return (op == OPC_INCSNZ_FR) || (op == OPC_INCSZ_FR);
    endfunction

    function automatic logic is_w_form(input opc_type op);
        return (op == OPC_INCSNZ_W) || (op == OPC_INCSZ_W);
    endfunction

    // One-hot register select, bit order following the register offsets.
    function automatic logic [3:0] reg_sel(input logic [APB_AW-1:0] a);
        logic [3:0] s;
        s[0] = (a == REG_ADDR);
        s[1] = (a == REG_DATA);
        s[2] = (a == REG_WORK);
        s[3] = (a == REG_STATUS);
        return s;
    endfunction

    state_type state_q;
    logic [1:0] wait_cnt_q;
    logic skip_q;
    logic sw_irq_q;
    logic rf_we_q;
    logic [FR_WIDTH-1:0] rf_waddr_q;
    logic [7:0] rf_wdata_q;
    logic [23:0] addr_q;
    logic [15:0] data_q;
    logic [7:0] work_q;
    logic [31:0] prdata_q;

    opc_type op;
    region_type region;
    logic accept;
    logic exec;
    logic [7:0] sum;
    logic take_skip;
    logic read_ok;
    logic read_blocks;
    logic eng_start;
    logic eng_busy;
    logic eng_done;
    logic [15:0] eng_data;
    logic apb_wr;
    logic apb_hit;
    logic [3:0] sel;
    logic addr_wr_en;
    logic data_wr_en;
    logic work_wr_en;
    logic fr_wr;
    logic w_wr;
    logic read_wait;
    logic [31:0] rd_word;

    assign op = decode(instr_word);
    assign region = region_of(addr_q);
    assign rf_raddr = instr_word[FR_MSB:0];
    assign sum = rf_rdata + 8'h01;

    // A read waits for issue while an earlier non-blocking one is in flight.
    assign read_wait = is_read(op) && !skip_q && eng_busy;
    assign instr_ready = (state_q == ST_IDLE) && !read_wait;
    assign accept = instr_valid && instr_ready;
    assign exec = accept && !skip_q;
    assign fr_wr = exec && is_fr_form(op);
    assign w_wr = exec && is_w_form(op);

    always_comb begin
        take_skip = 1'b0;
        unique case (op)
            OPC_INCSNZ_FR, OPC_INCSNZ_W: take_skip = (sum != 8'h00);
            OPC_INCSZ_FR, OPC_INCSZ_W: take_skip = (sum == 8'h00);
            default: take_skip = 1'b0;
        endcase
    end

    // The auto-increment form has no external memory source.
    always_comb begin
        read_ok = 1'b0;
        if (op == OPC_PMREAD) begin
            read_ok = (region != RGN_NONE);
        end else if (op == OPC_PMREADI) begin
            read_ok = (region == RGN_PRAM) || (region == RGN_FLASH);
        end
    end

    // Flash read from flash cannot overlap fetches, so it must stall.
    assign read_blocks = (region == RGN_PRAM) ||
        ((region == RGN_FLASH) && !exec_from_pram);
    assign eng_start = exec && read_ok;

    pm_read_engine u_engine (
        .pclk(pclk),
        .presetn(presetn),
        .start(eng_start),
        .start_addr(addr_q),
        .busy(eng_busy),
        .done(eng_done),
        .rdata(eng_data),
        .mem_req(mem_req),
        .mem_rsp(mem_rsp)
    );

    // Issue sequencing for the multi-cycle instructions.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            wait_cnt_q <= 2'b00;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (exec && op == OPC_SWINT) begin
                        state_q <= ST_WAIT;
                        wait_cnt_q <= SWINT_EXTRA;
                    end else if (eng_start && read_blocks) begin
                        state_q <= ST_BLOCK;
                        wait_cnt_q <= READ_EXTRA;
                    end
                end
                ST_WAIT: begin
                    if (wait_cnt_q == 2'b00) begin
                        state_q <= ST_IDLE;
                    end else begin
                        wait_cnt_q <= wait_cnt_q - 2'b01;
                    end
                end
                ST_BLOCK: begin
                    // Slow memory stretches the stall past four cycles.
                    // Issue resumes once the word is acknowledged: it lands
                    // in the data pair on the same edge that ends the stall.
                    if (wait_cnt_q != 2'b00) begin
                        wait_cnt_q <= wait_cnt_q - 2'b01;
                    end else if (!mem_req.valid) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // The skipped slot consumes the next accepted instruction.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_q <= 1'b0;
        end else if (exec && take_skip) begin
            skip_q <= 1'b1;
        end else if (accept) begin
            skip_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_irq_q <= 1'b0;
        end else begin
            sw_irq_q <= exec && (op == OPC_SWINT) &&
                global_irq_enable && !irq_in_service;
        end
    end

    // Write-back to the register file; flags are never touched.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rf_we_q <= 1'b0;
            rf_waddr_q <= '0;
            rf_wdata_q <= 8'h00;
        end else begin
            rf_we_q <= fr_wr;
            if (exec) begin
                rf_waddr_q <= instr_word[FR_MSB:0];
                rf_wdata_q <= sum;
            end
        end
    end

    assign apb_wr = psel && penable && pwrite;
    assign sel = reg_sel(paddr);
    assign apb_hit = |sel;
    assign addr_wr_en = apb_wr && sel[0];
    assign data_wr_en = apb_wr && sel[1];
    assign work_wr_en = apb_wr && sel[2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            work_q <= WORK_RESET;
        end else if (w_wr) begin
            work_q <= sum;
        end else if (work_wr_en) begin
            work_q <= pwdata[7:0];
        end
    end

    // The auto-increment touches only the low byte, without carry.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= ADDR_RESET;
        end else if (exec && op == OPC_PMREADI && read_ok) begin
            addr_q[7:0] <= addr_q[7:0] + ADDRL_STEP;
        end else if (addr_wr_en) begin
            addr_q <= pwdata[23:0];
        end
    end

    // Returned data wins over a software write in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= DATA_RESET;
        end else if (eng_done) begin
            data_q <= eng_data;
        end else if (data_wr_en) begin
            data_q <= pwdata[15:0];
        end
    end

    always_comb begin
        rd_word = 32'h00000000;
        unique case (paddr)
            REG_ADDR: rd_word[23:0] = addr_q;
            REG_DATA: rd_word[15:0] = data_q;
            REG_WORK: rd_word[7:0] = work_q;
            REG_STATUS: begin
                rd_word[ST_READ_BUSY] = eng_busy;
                rd_word[ST_SKIP] = skip_q;
                rd_word[ST_STALL] = (state_q != ST_IDLE);
            end
            default: rd_word = 32'h00000000;
        endcase
    end

    // Read data is captured in the setup phase, so the access phase drives
    // prdata straight from flip-flops; the price is that a status word
    // read back is one cycle old.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (psel && !penable) begin
            prdata_q <= rd_word;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !apb_hit;
    assign sw_irq = sw_irq_q;
    assign skip_pending = skip_q;
    assign rf_we = rf_we_q;
    assign rf_waddr = rf_waddr_q;
    assign rf_wdata = rf_wdata_q;

endmodule

// >>> verif/incskip_chk.sv
// Port assertions for the increment-skip and program read block.
`timescale 1ns/1ps
module incskip_chk
    import incskip_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic instr_ready,
    input wire logic exec_from_pram,
    input wire logic global_irq_enable,
    input wire logic irq_in_service,
    input wire logic sw_irq,
    input wire logic skip_pending,
    input wire logic [FR_WIDTH-1:0] rf_raddr,
    input wire logic [7:0] rf_rdata,
    input wire logic rf_we,
    input wire logic [FR_WIDTH-1:0] rf_waddr,
    input wire logic [7:0] rf_wdata,
    input wire mem_req_type mem_req,
    input wire mem_rsp_type mem_rsp
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic go;
    logic blk;
    logic [15:0] hi;
    assign go = instr_valid && instr_ready && !skip_pending;
    assign hi = instr_word & OP_MASK_REG;
    assign blk = mem_req.addr <= PRAM_LAST ||
        (mem_req.addr >= FLASH_BASE && mem_req.addr <= FLASH_LAST &&
        !exec_from_pram);
    sequence s_fr;
        go && (hi == OP_INCSNZ_FR || hi == OP_INCSZ_FR);
    endsequence
    sequence s_wf;
        go && (hi == OP_INCSNZ_W || hi == OP_INCSZ_W);
    endsequence
    sequence s_rd;
        go && (instr_word == OP_PMREAD || instr_word == OP_PMREADI);
    endsequence
    a_operand_field: assert property (rf_raddr == instr_word[FR_MSB:0])
        else $error("operand address not taken from opcode");
    a_fr_writeback: assert property (s_fr |=> rf_we &&
        rf_wdata == $past(rf_rdata) + 8'h01 && rf_waddr == $past(rf_raddr))
        else $error("register write back wrong");
    a_w_keeps_reg: assert property (s_wf |=> !rf_we)
        else $error("working register form wrote the register");
    a_nz_skip: assert property (go && (hi == OP_INCSNZ_FR ||
        hi == OP_INCSNZ_W) |=> skip_pending == ($past(rf_rdata) != 8'hff))
        else $error("skip on nonzero wrong");
    a_z_skip: assert property (go && (hi == OP_INCSZ_FR ||
        hi == OP_INCSZ_W) |=> skip_pending == ($past(rf_rdata) == 8'hff))
        else $error("skip on zero wrong");
    a_skip_idle: assert property (skip_pending && instr_valid &&
        instr_ready |=> !rf_we && !sw_irq && !skip_pending)
        else $error("skipped word had an effect");
    a_swint_fire: assert property (go && instr_word == OP_SWINT |=>
        sw_irq == ($past(global_irq_enable) && !$past(irq_in_service)))
        else $error("software interrupt condition wrong");
    a_swint_len: assert property (go && instr_word == OP_SWINT |=>
        !instr_ready [*2])
        else $error("software interrupt too short");
    a_req_hold: assert property (mem_req.valid && !mem_rsp.ack |=>
        mem_req.valid && $stable(mem_req.addr))
        else $error("memory request dropped before ack");
    a_block_len: assert property (s_rd ##1 (mem_req.valid && blk) |->
        !instr_ready [*3])
        else $error("blocking read released issue early");
endmodule

bind incskip_exec incskip_chk u_chk (.pclk, .presetn, .instr_valid,
    .instr_word, .instr_ready, .exec_from_pram, .global_irq_enable,
    .irq_in_service, .sw_irq, .skip_pending, .rf_raddr, .rf_rdata, .rf_we,
    .rf_waddr, .rf_wdata, .mem_req, .mem_rsp);

// >>> verif/pm_mem_model.sv
// Behavioural program memory answering one word read after a set delay.
`timescale 1ns/1ps
module pm_mem_model
    import incskip_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire mem_req_type mem_req,
    input wire logic [3:0] delay,
    output mem_rsp_type mem_rsp
);
    logic [3:0] wait_q;
    // Data toggles outside the ack cycle so a stale word never passes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_rsp <= '0;
            wait_q <= 4'h0;
        end else if (!mem_rsp.ack && mem_req.valid && wait_q >= delay) begin
            mem_rsp.ack <= 1'b1;
            mem_rsp.data <= mem_req.addr[15:0] ^ 16'h5a3c;
            wait_q <= 4'h0;
        end else begin
            mem_rsp.ack <= 1'b0;
            mem_rsp.data <= ~mem_rsp.data;
            if (mem_req.valid && !mem_rsp.ack) begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule

// >>> verif/test_incskip_exec.sv
// Self-checking bench for the increment-skip and program read block.
`timescale 1ns/1ps
module test_incskip_exec
    import incskip_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, r;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic instr_valid, instr_ready, exec_from_pram, global_irq_enable;
    logic irq_in_service, sw_irq, skip_pending, rf_we, c_we, c_skip, c_irq;
    logic [15:0] instr_word;
    logic [8:0] rf_raddr, rf_waddr, c_wa;
    logic [7:0] rf_rdata, rf_wdata, c_wd, exp_w;
    logic [3:0] delay;
    mem_req_type mem_req;
    mem_rsp_type mem_rsp;
    int fails, check_count;
    incskip_exec u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .instr_valid, .instr_word,
        .instr_ready, .exec_from_pram, .global_irq_enable, .irq_in_service,
        .sw_irq, .skip_pending, .rf_raddr, .rf_rdata, .rf_we, .rf_waddr,
        .rf_wdata, .mem_req, .mem_rsp);
    pm_mem_model u_mem (.pclk, .presetn, .mem_req, .delay, .mem_rsp);
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic hang();
        fails++;
        tally_and_finish();
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            r = pready;
            rd = prdata;
            e = pslverr;
            if (r === 1'b1) break;
        end
        if (k == 20) hang();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check(rd, x);
    endtask
    task automatic issue(input logic [15:0] w, input logic last);
        int k;
        instr_valid <= 1'b1;
        instr_word <= w;
        for (k = 0; k < 50; k++) begin
            @(negedge pclk);
            if (k == 0) begin
                c_we = rf_we;
                c_wd = rf_wdata;
                c_wa = rf_waddr;
                c_skip = skip_pending;
            end
            r = instr_ready;
            @(posedge pclk);
            if (r === 1'b1) break;
        end
        if (k == 50) hang();
        if (last) begin
            instr_valid <= 1'b0;
            instr_word <= 16'h0000;
        end
    endtask
    task automatic cyc(output int n);
        n = 1;
        while (n < 50) begin
            @(negedge pclk);
            if (n == 1) c_irq = sw_irq;
            if (instr_ready === 1'b1) break;
            n++;
        end
        if (n == 50) hang();
        @(posedge pclk);
    endtask
    task automatic t_reg();
        rdc(REG_ADDR, 32'h0);
        rdc(REG_DATA, 32'h0);
        rdc(REG_STATUS, 32'h0);
        apb(1'b1, REG_WORK, 32'h000000a7);
        rdc(REG_WORK, 32'h000000a7);
        apb(1'b0, 12'h010, 32'h0);
        check(e, 1'b1);
        check(rd, 32'h0);
        exp_w = 8'ha7;
        $display("test registers done");
    endtask
    task automatic t_inc();
        logic [15:0] ops [4];
        logic [7:0] s;
        logic sk, fr;
        int i;
        ops = '{OP_INCSNZ_FR, OP_INCSNZ_W, OP_INCSZ_FR, OP_INCSZ_W};
        for (i = 0; i < 8; i++) begin
            rf_rdata <= i[0] ? 8'hff : 8'h05;
            s = i[0] ? 8'h00 : 8'h06;
            fr = ops[i/2][9];
            sk = ops[i/2][14] ? (s != 8'h00) : (s == 8'h00);
            issue(ops[i/2] | 16'(9'h100 + i), 1'b0);
            issue(OP_INCSNZ_FR | 16'h01aa, 1'b0);
            check(c_skip, sk);
            check(c_we, fr);
            if (fr) check({c_wa, c_wd}, {9'(9'h100 + i), s});
            if (!fr) exp_w = s;
            issue(16'h0000, 1'b1);
            check(c_we, !sk);
            if (!sk) check(c_wd, s);
            rdc(REG_WORK, {24'h0, exp_w});
        end
        $display("test increment skip done");
    endtask
    task automatic t_swint();
        int i, n;
        for (i = 0; i < 4; i++) begin
            global_irq_enable <= i[0];
            irq_in_service <= i[1];
            issue(OP_SWINT, 1'b1);
            cyc(n);
            check(c_irq, i[0] & !i[1]);
            check(n, 3);
        end
        $display("test software interrupt done");
    endtask
    task automatic rcase(input logic [15:0] op, input logic [23:0] a,
            input logic pr, input logic [3:0] dl, input int ne,
            input logic rq);
        logic [23:0] na;
        int n, k;
        apb(1'b1, REG_DATA, 32'h0000beef);
        apb(1'b1, REG_ADDR, {8'h00, a});
        exec_from_pram <= pr;
        delay <= dl;
        issue(op, 1'b1);
        cyc(n);
        check(n, ne);
        for (k = 0; k < 40; k++) begin
            apb(1'b0, REG_STATUS, 32'h0);
            if (rd[ST_READ_BUSY] === 1'b0) break;
        end
        if (k == 40) hang();
        na = a;
        if (rq && op == OP_PMREADI) na[7:0] = a[7:0] + 8'h02;
        rdc(REG_ADDR, {8'h00, na});
        rdc(REG_DATA, rq ? {16'h0, a[15:0] ^ 16'h5a3c} : 32'hbeef);
    endtask
    task automatic t_read();
        rcase(OP_PMREAD, 24'h000380, 1'b0, 4'h0, 4, 1'b1);
        rcase(OP_PMREAD, 24'h018380, 1'b0, 4'h0, 4, 1'b1);
        rcase(OP_PMREAD, 24'h018380, 1'b1, 4'h7, 1, 1'b1);
        rcase(OP_PMREAD, 24'h800010, 1'b0, 4'h3, 1, 1'b1);
        rcase(OP_PMREADI, 24'h0003fe, 1'b0, 4'h0, 4, 1'b1);
        rcase(OP_PMREADI, 24'h018384, 1'b1, 4'h5, 1, 1'b1);
        rcase(OP_PMREADI, 24'h800010, 1'b0, 4'h0, 1, 1'b0);
        rcase(OP_PMREAD, 24'h400000, 1'b0, 4'h0, 1, 1'b0);
        $display("test program read done");
    endtask
    initial begin
        {presetn, psel, penable, pwrite, instr_valid} = 5'h0;
        {exec_from_pram, global_irq_enable, irq_in_service} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        instr_word = 16'h0000;
        rf_rdata = 8'h00;
        delay = 4'h0;
        fails = 0;
        check_count = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reg();
        t_inc();
        t_swint();
        t_read();
        tally_and_finish();
    end
endmodule
